// ===== rtl/dpt_timer.sv
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
// Functional notes
// - Per-timer source select: slow or fast clock
// - Division field: 256, 32, 4, or 1
// - Source and ratio independent per timer
// - Event mode: timer 0 counts external input
// - Run bit passes divided clock to counter
// - Underflow sets flag, raises interrupt request
// - Mask blocks request, flag still set
// - Timer output toggles on each underflow
// - Channel select picks timer 0 or 1
// - Output enable drives pin, else high
// - Enable gating unsynchronised, glitch possible; here the pin is registered, no glitch
// - Timer 1 halved underflow clocks serial
// - Mode register bits 2..0, bit 3 zero
// - Control: division 3:2, trigger 1, run 0
// - Reload as two readable nibbles, reset zero
// - Count readable as two read-only nibbles
// - Mask register bits 1:0, upper zero
// - Output register: out_channel_sel, enable, source selects
// - Reload on trigger and every underflow
// - Trigger reloads count, running or stopped
// - Low-nibble read latches high nibble
// - Flags clear by writing one
module dpt_timer #(
    parameter int CNT_W = 8 // Counter width
) (
    input wire logic clk_in, // System clock, 100 MHz
    input wire logic rst_b_in, // Async reset, active low
    input wire logic slow_osc_clk_in, // Slow oscillator level
    input wire logic fast_osc_clk_in, // Fast oscillator level
    input wire logic event_input_pin_in, // Event count pulse
    input wire logic [dpt_pkg::ADDR_W-1:0] s_axi_awaddr, // AW address
    input wire logic s_axi_awvalid, // AW valid
    output logic s_axi_awready, // AW ready
    input wire logic [31:0] s_axi_wdata, // W data
    input wire logic [3:0] s_axi_wstrb, // W strobes
    input wire logic s_axi_wvalid, // W valid
    output logic s_axi_wready, // W ready
    output logic [1:0] s_axi_bresp, // B response
    output logic s_axi_bvalid, // B valid
    input wire logic s_axi_bready, // B ready
    input wire logic [dpt_pkg::ADDR_W-1:0] s_axi_araddr, // AR address
    input wire logic s_axi_arvalid, // AR valid
    output logic s_axi_arready, // AR ready
    output logic [31:0] s_axi_rdata, // R data
    output logic [1:0] s_axi_rresp, // R response
    output logic s_axi_rvalid, // R valid
    input wire logic s_axi_rready, // R ready
    output logic t0_irq_out, // Timer 0 masked request
    output logic t1_irq_out, // Timer 1 masked request
    output logic out_port_pin_out, // Timer output pin level
    output logic serial_clk_out // Serial interface clock
);
    logic [2:0] mode_ff;
    logic [3:0] outsel_ff;
    logic [1:0] div0_ff, div1_ff;
    logic run0_ff, run1_ff;
    logic [CNT_W-1:0] rld0_ff, rld1_ff, cnt0_ff, cnt1_ff;
    logic [3:0] hold0_ff, hold1_ff;
    logic [1:0] ien_ff, iflg_ff;
    logic tout0_ff, tout1_ff, ser_ff;
    logic [2:0] sync_s_ff, sync_f_ff, sync_e_ff;
    logic [7:0] pre0_ff, pre1_ff;
    logic aw_ff, w_ff;
    logic [dpt_pkg::ADDR_W-1:0] awa_ff;
    logic [31:0] wd_ff;
    logic [3:0] ws_ff;
    logic wr_go, trig0, trig1, rd_go, map_ok;
    logic tick_s, tick_f, tick_e, src0, src1;
    logic clk0, clk1, uf0, uf1;
    logic [15:0] wa, ra;
    logic [3:0] wn, rd_nib;

    // ---------------------------------------------------------
    // Oscillator and event input edge detection
    // ---------------------------------------------------------
    // Stage 0 feeds only stage 1; edges taken from stages 1 and 2
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync_s_ff <= 3'h0;
            sync_f_ff <= 3'h0;
            sync_e_ff <= 3'h0;
        end else begin
            sync_s_ff <= {sync_s_ff[1:0], slow_osc_clk_in};
            sync_f_ff <= {sync_f_ff[1:0], fast_osc_clk_in};
            sync_e_ff <= {sync_e_ff[1:0], event_input_pin_in};
        end
    end
    assign tick_s = sync_s_ff[1] & ~sync_s_ff[2];
    assign tick_f = sync_f_ff[1] & ~sync_f_ff[2];
    assign tick_e = sync_e_ff[1] & ~sync_e_ff[2];
    assign src0 = outsel_ff[dpt_pkg::OUT_T0_SRC_SEL] ? tick_f : tick_s;
    assign src1 = outsel_ff[dpt_pkg::OUT_T1_SRC_SEL] ? tick_f : tick_s;

    function automatic logic [7:0] div_mask(input logic [1:0] d);
        case (dpt_pkg::dpt_div_t'(d))
            dpt_pkg::DIV_4: div_mask = dpt_pkg::DIV_MASK_4;
            dpt_pkg::DIV_32: div_mask = dpt_pkg::DIV_MASK_32;
            dpt_pkg::DIV_256: div_mask = dpt_pkg::DIV_MASK_256;
            default: div_mask = dpt_pkg::DIV_MASK_1;
        endcase
    endfunction

    // ---------------------------------------------------------
    // Prescalers
    // ---------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pre0_ff <= dpt_pkg::RST_BYTE;
            pre1_ff <= dpt_pkg::RST_BYTE;
        end else begin
            if (!run0_ff)
                pre0_ff <= dpt_pkg::RST_BYTE;
            else if (src0)
                pre0_ff <= pre0_ff + 8'h01;
            if (!run1_ff)
                pre1_ff <= dpt_pkg::RST_BYTE;
            else if (src1)
                pre1_ff <= pre1_ff + 8'h01;
        end
    end
    // Count clock on a source tick when prescaler bits under the mask are all ones; timer 0 in event mode counts the event tick
    assign clk0 = run0_ff & (mode_ff[dpt_pkg::MODE_EVT] ? tick_e :
        (src0 && (pre0_ff & div_mask(div0_ff)) == div_mask(div0_ff)));
    assign clk1 = run1_ff & src1 &
        ((pre1_ff & div_mask(div1_ff)) == div_mask(div1_ff));
    assign uf0 = clk0 && cnt0_ff == '0;
    assign uf1 = clk1 && cnt1_ff == '0;

    // ---------------------------------------------------------
    // AXI4-Lite write path
    // ---------------------------------------------------------
    assign wr_go = aw_ff & w_ff & ~s_axi_bvalid;
    assign wa = awa_ff[17:2];
    assign wn = ws_ff[0] ? wd_ff[3:0] : 4'h0;
    assign trig0 = wr_go && ws_ff[0] && wa == dpt_pkg::IDX_T0CTL &&
        wd_ff[dpt_pkg::CTL_TRIG];
    assign trig1 = wr_go && ws_ff[0] && wa == dpt_pkg::IDX_T1CTL &&
        wd_ff[dpt_pkg::CTL_TRIG];

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awa_ff <= '0;
            wd_ff <= 32'h0;
            ws_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= dpt_pkg::RESP_OKAY;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            // Readies low from acceptance until the response is taken
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff <= 1'b1;
                awa_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff <= 1'b1;
                s_axi_wready <= 1'b0;
                wd_ff <= s_axi_wdata;
                ws_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= map_ok ? dpt_pkg::RESP_OKAY :
                    dpt_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_comb begin
        case (wa)
            dpt_pkg::IDX_MODE, dpt_pkg::IDX_OUTSEL, dpt_pkg::IDX_T0CTL,
            dpt_pkg::IDX_T1CTL, dpt_pkg::IDX_T0RLL, dpt_pkg::IDX_T0RLH,
            dpt_pkg::IDX_T1RLL, dpt_pkg::IDX_T1RLH, dpt_pkg::IDX_T0CNL,
            dpt_pkg::IDX_T0CNH, dpt_pkg::IDX_T1CNL, dpt_pkg::IDX_T1CNH,
            dpt_pkg::IDX_IEN, dpt_pkg::IDX_IFLG: map_ok = 1'b1;
            default: map_ok = 1'b0;
        endcase
    end

    // ---------------------------------------------------------
    // Control registers
    // ---------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_ff <= 3'h0;
            outsel_ff <= dpt_pkg::RST_NIB;
            div0_ff <= 2'h0;
            div1_ff <= 2'h0;
            run0_ff <= 1'b0;
            run1_ff <= 1'b0;
            rld0_ff <= dpt_pkg::RST_BYTE;
            rld1_ff <= dpt_pkg::RST_BYTE;
            ien_ff <= 2'h0;
        end else if (wr_go && ws_ff[0]) begin
            case (wa)
                dpt_pkg::IDX_MODE: mode_ff <= wn[2:0];
                dpt_pkg::IDX_OUTSEL: outsel_ff <= wn;
                dpt_pkg::IDX_T0CTL: begin
                    div0_ff <= wn[3:2];
                    run0_ff <= wn[dpt_pkg::CTL_RUN];
                end
                dpt_pkg::IDX_T1CTL: begin
                    div1_ff <= wn[3:2];
                    run1_ff <= wn[dpt_pkg::CTL_RUN];
                end
                dpt_pkg::IDX_T0RLL: rld0_ff[3:0] <= wn;
                dpt_pkg::IDX_T0RLH: rld0_ff[7:4] <= wn;
                dpt_pkg::IDX_T1RLL: rld1_ff[3:0] <= wn;
                dpt_pkg::IDX_T1RLH: rld1_ff[7:4] <= wn;
                dpt_pkg::IDX_IEN: ien_ff <= wn[1:0];
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------
    // Down counters
    // ---------------------------------------------------------
    // Trigger loads the count from reload, whether running or stopped
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt0_ff <= dpt_pkg::RST_BYTE;
            cnt1_ff <= dpt_pkg::RST_BYTE;
        end else begin
            if (trig0 || uf0)
                cnt0_ff <= rld0_ff;
            else if (clk0)
                cnt0_ff <= cnt0_ff - 8'h01;
            if (trig1 || uf1)
                cnt1_ff <= rld1_ff;
            else if (clk1)
                cnt1_ff <= cnt1_ff - 8'h01;
        end
    end

    // ---------------------------------------------------------
    // Flags, timer output, serial clock
    // ---------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            iflg_ff <= 2'h0;
        end else begin
            // Set wins over a same-cycle clear
            if (uf0)
                iflg_ff[0] <= 1'b1;
            else if (wr_go && ws_ff[0] && wa == dpt_pkg::IDX_IFLG && wn[0])
                iflg_ff[0] <= 1'b0;
            if (uf1)
                iflg_ff[1] <= 1'b1;
            else if (wr_go && ws_ff[0] && wa == dpt_pkg::IDX_IFLG && wn[1])
                iflg_ff[1] <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tout0_ff <= 1'b0;
            tout1_ff <= 1'b0;
            ser_ff <= 1'b0;
            out_port_pin_out <= 1'b1;
            t0_irq_out <= 1'b0;
            t1_irq_out <= 1'b0;
        end else begin
            if (uf0)
                tout0_ff <= ~tout0_ff;
            if (uf1)
                tout1_ff <= ~tout1_ff;
            ser_ff <= run1_ff & tout1_ff;
            // Gate registered together with the selected toggle; no glitch reaches the pin
            out_port_pin_out <= ~outsel_ff[dpt_pkg::OUT_EN] |
                (outsel_ff[dpt_pkg::OUT_OUT_CHANNEL_SEL] ? tout1_ff : tout0_ff);
            t0_irq_out <= iflg_ff[0] & ien_ff[0];
            t1_irq_out <= iflg_ff[1] & ien_ff[1];
        end
    end
    assign serial_clk_out = ser_ff;

    // ---------------------------------------------------------
    // AXI4-Lite read path
    // ---------------------------------------------------------
    assign rd_go = s_axi_arvalid & s_axi_arready;
    assign ra = s_axi_araddr[17:2];

    always_comb begin
        case (ra)
            dpt_pkg::IDX_MODE: rd_nib = {1'b0, mode_ff};
            dpt_pkg::IDX_OUTSEL: rd_nib = outsel_ff;
            dpt_pkg::IDX_T0CTL: rd_nib = {div0_ff, 1'b0, run0_ff};
            dpt_pkg::IDX_T1CTL: rd_nib = {div1_ff, 1'b0, run1_ff};
            dpt_pkg::IDX_T0RLL: rd_nib = rld0_ff[3:0];
            dpt_pkg::IDX_T0RLH: rd_nib = rld0_ff[7:4];
            dpt_pkg::IDX_T1RLL: rd_nib = rld1_ff[3:0];
            dpt_pkg::IDX_T1RLH: rd_nib = rld1_ff[7:4];
            dpt_pkg::IDX_T0CNL: rd_nib = cnt0_ff[3:0];
            dpt_pkg::IDX_T0CNH: rd_nib = hold0_ff;
            dpt_pkg::IDX_T1CNL: rd_nib = cnt1_ff[3:0];
            dpt_pkg::IDX_T1CNH: rd_nib = hold1_ff;
            dpt_pkg::IDX_IEN: rd_nib = {2'h0, ien_ff};
            dpt_pkg::IDX_IFLG: rd_nib = {2'h0, iflg_ff};
            default: rd_nib = 4'h0;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= dpt_pkg::RESP_OKAY;
            s_axi_arready <= 1'b1;
            hold0_ff <= dpt_pkg::RST_NIB;
            hold1_ff <= dpt_pkg::RST_NIB;
        end else begin
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_arready <= 1'b0;
                s_axi_rdata <= {28'h0, rd_nib};
                s_axi_rresp <= (ra == dpt_pkg::IDX_MODE || rd_nib != 4'h0 ||
                    (ra >= dpt_pkg::IDX_OUTSEL && ra <= dpt_pkg::IDX_T1CNH) ||
                    ra == dpt_pkg::IDX_IEN || ra == dpt_pkg::IDX_IFLG) ?
                    dpt_pkg::RESP_OKAY : dpt_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
            if (rd_go && ra == dpt_pkg::IDX_T0CNL)
                hold0_ff <= cnt0_ff[7:4];
            if (rd_go && ra == dpt_pkg::IDX_T1CNL)
                hold1_ff <= cnt1_ff[7:4];
        end
    end

    // ---------------------------------------------------------
    // Checks
    // ---------------------------------------------------------
    chk_uf_reload: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        uf0 |=> cnt0_ff == $past(rld0_ff))
        else $error("reload missing after underflow");
    chk_flag_set: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        uf1 |=> iflg_ff[1])
        else $error("flag not set on underflow");
    chk_irq_mask: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !ien_ff[0] |=> !t0_irq_out)
        else $error("masked request raised");
    chk_timer_out_signal_toggle: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        uf0 |=> tout0_ff != $past(tout0_ff))
        else $error("output did not toggle");
    chk_pin_high: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !outsel_ff[dpt_pkg::OUT_EN] |=> out_port_pin_out)
        else $error("pin not high while disabled");
    chk_stop_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (!run1_ff && !trig1) |=> $stable(cnt1_ff))
        else $error("stopped counter changed");
    chk_clear_one: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (iflg_ff[0] && !uf0 && !clk0 && wr_go && ws_ff[0] &&
        wa == dpt_pkg::IDX_IFLG && wn[0]) |=> !iflg_ff[0])
        else $error("flag clear failed");
    chk_event_src: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (mode_ff[dpt_pkg::MODE_EVT] && run0_ff && tick_e && !trig0 &&
        cnt0_ff != '0) |=> cnt0_ff == $past(cnt0_ff) - 8'h01)
        else $error("event mode did not count");
    chk_serial_clk: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        !run1_ff |=> !serial_clk_out)
        else $error("serial clock while stopped");
endmodule // dpt_timer

// ===== rtl/dpt_pkg.sv
package dpt_pkg;
    // -------------------------------------------------------------
    // Register indices; the bus byte address is four times the index
    // -------------------------------------------------------------
    localparam logic [15:0] IDX_MODE = 16'hffc0;
    localparam logic [15:0] IDX_OUTSEL = 16'hffc1;
    localparam logic [15:0] IDX_T0CTL = 16'hffc2;
    localparam logic [15:0] IDX_T1CTL = 16'hffc3;
    localparam logic [15:0] IDX_T0RLL = 16'hffc4;
    localparam logic [15:0] IDX_T0RLH = 16'hffc5;
    localparam logic [15:0] IDX_T1RLL = 16'hffc6;
    localparam logic [15:0] IDX_T1RLH = 16'hffc7;
    localparam logic [15:0] IDX_T0CNL = 16'hffc8;
    localparam logic [15:0] IDX_T0CNH = 16'hffc9;
    localparam logic [15:0] IDX_T1CNL = 16'hffca;
    localparam logic [15:0] IDX_T1CNH = 16'hffcb;
    localparam logic [15:0] IDX_IEN = 16'hffe2;
    localparam logic [15:0] IDX_IFLG = 16'hfff2;
    localparam int ADDR_W = 18;
    // -------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------
    localparam int CTL_RUN = 0;
    localparam int CTL_TRIG = 1;
    localparam int CTL_DIV_LO = 2;
    localparam int OUT_T0_SRC_SEL = 0;
    localparam int OUT_T1_SRC_SEL = 1;
    localparam int OUT_EN = 2;
    localparam int OUT_OUT_CHANNEL_SEL = 3;
    localparam int MODE_EVT = 2;
    // -------------------------------------------------------------
    // Reset values and division ratios
    // -------------------------------------------------------------
    localparam logic [3:0] RST_NIB = 4'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] DIV_MASK_1 = 8'h00;
    localparam logic [7:0] DIV_MASK_4 = 8'h03;
    localparam logic [7:0] DIV_MASK_32 = 8'h1f;
    localparam logic [7:0] DIV_MASK_256 = 8'hff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {DIV_1, DIV_4, DIV_32, DIV_256} dpt_div_t;
endpackage

// ===== verification/dpt_osc_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Oscillators and external event source
// ----------------------------------------------------------------
module dpt_osc_model #(
    parameter int SLOW_HALF = 100, // Slow half period in ns
    parameter int FAST_HALF = 30 // Fast half period in ns
) (
    output logic slow_osc_clk_out, // Slow oscillator
    output logic fast_osc_clk_out, // Fast oscillator
    output logic event_pin_out // External event line
);
    // Fast source runs from time zero, settled before any start
    initial begin
        fast_osc_clk_out = 1'b0;
        forever #FAST_HALF fast_osc_clk_out = ~fast_osc_clk_out;
    end
    initial begin
        slow_osc_clk_out = 1'b0;
        forever #SLOW_HALF slow_osc_clk_out = ~slow_osc_clk_out;
    end
    initial event_pin_out = 1'b0;
    // Wide pulses so the two-flop synchroniser never misses one
    task automatic pulse(input int n);
        repeat (n) begin
            #50 event_pin_out <= 1'b1;
            #50 event_pin_out <= 1'b0;
        end
    endtask
endmodule // dpt_osc_model

// ===== verification/dual_prescaled_down_timer_bench.sv
`timescale 1ns/10ps
module dual_prescaled_down_timer_bench;
    logic clk_in, rst_b_in, slow_osc, fast_osc, evt;
    logic [17:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic t0_irq, t1_irq, pin, sclk;
    int mismatches, checks, i;
    int divs [4] = '{1, 4, 32, 256};
    dpt_osc_model osc (.slow_osc_clk_out(slow_osc),
        .fast_osc_clk_out(fast_osc), .event_pin_out(evt));
    dpt_timer dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .slow_osc_clk_in(slow_osc), .fast_osc_clk_in(fast_osc),
        .event_input_pin_in(evt), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .t0_irq_out(t0_irq), .t1_irq_out(t1_irq),
        .out_port_pin_out(pin), .serial_clk_out(sclk));
    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask
    task automatic tmo(input string what);
        mismatches++;
        $display("[ERR] %0t timeout in %s", $time, what);
        final_report();
    endtask
    // ------------------------------------------------------------
    // Bus tasks: handshakes judged on values settled before the edge
    // ------------------------------------------------------------
    task automatic wr(input logic [15:0] idx, input logic [3:0] d);
        int n;
        logic ah, wh, bh, done;
        done = 1'b0;
        @(posedge clk_in);
        awaddr <= {idx, 2'b00};
        wdata <= {28'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 64 && !done; n++) begin
            @(negedge clk_in);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid && bready;
            resp = bresp;
            @(posedge clk_in);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (bh) begin
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) tmo("write");
    endtask
    task automatic rdx(input logic [15:0] idx);
        int n;
        logic ah, rh, done;
        done = 1'b0;
        @(posedge clk_in);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 64 && !done; n++) begin
            @(negedge clk_in);
            ah = arvalid && arready;
            rh = rvalid && rready;
            rd = rdata;
            resp = rresp;
            @(posedge clk_in);
            if (ah) arvalid <= 1'b0;
            if (rh) begin
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) tmo("read");
    endtask
    task automatic rdc(input logic [15:0] idx, input logic [3:0] e,
        input string what);
        rdx(idx);
        chk(rd, {28'h0, e}, what);
        chk(resp, dpt_pkg::RESP_OKAY, what);
    endtask
    // Last gap counts; a restart may jump, so two waits only line up
    task automatic gap(input bit which, input int exp, input string what);
        int n;
        logic v;
        for (int k = 0; k < 3; k++) begin
            v = which ? pin : sclk;
            n = 0;
            while ((which ? pin : sclk) === v && n < 20000) begin
                @(negedge clk_in);
                n++;
            end
            if (n >= 20000) tmo(what);
        end
        chk(n, exp, what);
    endtask
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_b_in, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        mismatches = 0;
        checks = 0;
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'b1;
        chk(pin, 1'b1, "pin idle");
        chk(sclk, 1'b0, "serial idle");
        for (i = 0; i < 12; i++) rdc(16'(16'hffc0 + i), 4'h0, "rst");
        rdc(dpt_pkg::IDX_IEN, 4'h0, "rst ien");
        rdc(dpt_pkg::IDX_IFLG, 4'h0, "rst flags");
        rdx(16'hffd0);
        chk(resp, dpt_pkg::RESP_SLVERR, "unmapped rd");
        wr(16'hffd0, 4'hf);
        chk(resp, dpt_pkg::RESP_SLVERR, "unmapped wr");
        wr(dpt_pkg::IDX_MODE, 4'hf);
        rdc(dpt_pkg::IDX_MODE, 4'h7, "mode");
        wr(dpt_pkg::IDX_IEN, 4'hf);
        rdc(dpt_pkg::IDX_IEN, 4'h3, "ien");
        wr(dpt_pkg::IDX_T0CTL, 4'he);
        rdc(dpt_pkg::IDX_T0CTL, 4'hc, "ctl");
        wr(dpt_pkg::IDX_OUTSEL, 4'hf);
        rdc(dpt_pkg::IDX_OUTSEL, 4'hf, "outsel");
        wr(dpt_pkg::IDX_T0CNL, 4'h5);
        rdc(dpt_pkg::IDX_T0CNL, 4'h0, "count ro");
        wr(dpt_pkg::IDX_IEN, 4'h0);
        wr(dpt_pkg::IDX_OUTSEL, 4'h0);
        $display("done registers");
        wr(dpt_pkg::IDX_T0RLL, 4'h5);
        wr(dpt_pkg::IDX_T0RLH, 4'ha);
        rdc(dpt_pkg::IDX_T0RLL, 4'h5, "rld lo");
        rdc(dpt_pkg::IDX_T0RLH, 4'ha, "rld hi");
        wr(dpt_pkg::IDX_T0CTL, 4'h2);
        rdc(dpt_pkg::IDX_T0CNL, 4'h5, "trig lo");
        rdc(dpt_pkg::IDX_T0CNH, 4'ha, "trig hi");
        wr(dpt_pkg::IDX_MODE, 4'h4);
        wr(dpt_pkg::IDX_T0CTL, 4'hd);
        osc.pulse(3);
        wr(dpt_pkg::IDX_T0CTL, 4'hc);
        rdc(dpt_pkg::IDX_T0CNL, 4'h2, "event lo");
        rdc(dpt_pkg::IDX_T0CNH, 4'ha, "event hi");
        wr(dpt_pkg::IDX_T0CTL, 4'hd);
        osc.pulse(2);
        rdc(dpt_pkg::IDX_T0CNL, 4'h0, "latch lo");
        osc.pulse(1);
        rdc(dpt_pkg::IDX_T0CNH, 4'ha, "latch hi");
        rdc(dpt_pkg::IDX_T0CNL, 4'hf, "borrow lo");
        rdc(dpt_pkg::IDX_T0CNH, 4'h9, "borrow hi");
        wr(dpt_pkg::IDX_T0CTL, 4'h0);
        wr(dpt_pkg::IDX_MODE, 4'h0);
        $display("done event");
        // Slow source keeps the serial clock in range at every ratio
        wr(dpt_pkg::IDX_OUTSEL, 4'h0);
        for (i = 0; i < 4; i++) begin
            wr(dpt_pkg::IDX_T1CTL, {i[1:0], 2'b11});
            gap(1'b0, 20 * divs[i], "ratio");
            wr(dpt_pkg::IDX_T1CTL, 4'h0);
        end
        repeat (2) @(negedge clk_in);
        chk(sclk, 1'b0, "serial stop");
        chk(pin, 1'b1, "pin off");
        wr(dpt_pkg::IDX_T0RLL, 4'h1);
        wr(dpt_pkg::IDX_T0RLH, 4'h0);
        // Reload 8 on the fast source: serial clock just under its limit
        wr(dpt_pkg::IDX_T1RLL, 4'h8);
        wr(dpt_pkg::IDX_T0CTL, 4'h7);
        wr(dpt_pkg::IDX_T1CTL, 4'h3);
        wr(dpt_pkg::IDX_OUTSEL, 4'h6);
        gap(1'b1, 160, "t0 out");
        gap(1'b0, 54, "t1 serial");
        wr(dpt_pkg::IDX_OUTSEL, 4'he);
        gap(1'b1, 54, "t1 out");
        rdc(dpt_pkg::IDX_IFLG, 4'h3, "flags");
        chk(t0_irq, 1'b0, "masked");
        wr(dpt_pkg::IDX_IEN, 4'h1);
        repeat (2) @(negedge clk_in);
        chk(t0_irq, 1'b1, "t0 irq");
        chk(t1_irq, 1'b0, "t1 masked");
        wr(dpt_pkg::IDX_T0CTL, 4'h0);
        wr(dpt_pkg::IDX_T1CTL, 4'h0);
        wr(dpt_pkg::IDX_IFLG, 4'h0);
        rdc(dpt_pkg::IDX_IFLG, 4'h3, "clr zero");
        wr(dpt_pkg::IDX_IFLG, 4'h1);
        rdc(dpt_pkg::IDX_IFLG, 4'h2, "clr one");
        chk(t0_irq, 1'b0, "irq gone");
        wr(dpt_pkg::IDX_OUTSEL, 4'h0);
        repeat (2) @(negedge clk_in);
        chk(pin, 1'b1, "pin high");
        $display("done timer");
        final_report();
    end
endmodule // dual_prescaled_down_timer_bench
